// ### shared/sdem_pkg.sv
// sdem_pkg: constants for the servo deviation error monitor
// assumes a 100 MHz system clock and an apb register bus
package sdem_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_SELECT    = 8'h00;
    localparam logic [7:0] OFS_POS_THR   = 8'h04;
    localparam logic [7:0] OFS_SPD_THR   = 8'h08;
    localparam logic [7:0] OFS_THR_THR   = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h14;
    localparam logic [7:0] OFS_INT_EN    = 8'h18;
    localparam logic [7:0] OFS_CONTROL   = 8'h1C;
    localparam logic [7:0] OFS_ALARM     = 8'h20;
    // ****************************************
    // field positions
    // ****************************************
    localparam int SEL_POS_BIT   = 0;
    localparam int SEL_SPD_BIT   = 1;
    localparam int SEL_THR_BIT   = 2;
    localparam int CTL_RESET_BIT = 0;
    localparam int CTL_SVON_BIT  = 1;
    localparam int ST_POLE_BIT   = 3;
    localparam int ST_SVON_BIT   = 4;
    localparam int ST_TEST_BIT   = 5;
    localparam int ST_LINEAR_BIT = 6;
    // ****************************************
    // reset values and ranges
    // ****************************************
    localparam logic [2:0]  SELECT_RST   = 3'h3;
    localparam logic [15:0] POS_THR_RST  = 16'h0032;
    localparam logic [15:0] SPD_THR_RST  = 16'h03E8;
    localparam logic [15:0] THR_THR_RST  = 16'h0064;
    localparam logic [15:0] POS_THR_MIN  = 16'h0001;
    localparam logic [15:0] POS_THR_MAX  = 16'h03E8;
    localparam logic [15:0] SPD_THR_MIN  = 16'h0001;
    localparam logic [15:0] SPD_THR_MAX  = 16'h1388;
    localparam logic [15:0] THR_THR_MIN  = 16'h0001;
    localparam logic [15:0] THR_THR_MAX  = 16'h03E8;
    localparam logic [2:0]  SELECT_MIN   = 3'h1;
    // ****************************************
    // pole detection timing
    // ****************************************
    localparam int POLE_TIME_US    = 10;
    localparam int CLK_MHZ         = 100;
    localparam int POLE_CYCLES     = POLE_TIME_US * CLK_MHZ;
    // alarm codes that a linear motor never raises
    localparam logic [7:0] ALM_ABS_ERASED   = 8'h25;
    localparam logic [7:0] ALM_BATT_CABLE   = 8'h92;
    localparam logic [7:0] ALM_BATT_WARN    = 8'h9F;
    localparam logic [7:0] ALM_ABS_COUNTER  = 8'hE3;
endpackage : sdem_pkg

// ### logic/sdem_dev_check.sv
// sdem_dev_check: one deviation comparator with a latched alarm
// assumes both inputs are signed samples of the same control cycle
`timescale 1ns/1ps
`default_nettype none
module sdem_dev_check #(
    parameter int W         = 32,
    parameter bit INCLUSIVE = 1'b0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         sample,
    input  wire logic         enable,
    input  wire logic         clear,
    input  wire logic [W-1:0] value_a,
    input  wire logic [W-1:0] value_b,
    input  wire logic [15:0]  threshold,
    output logic              alarm,
    output logic              trip
);
    // ****************************************
    // magnitude compare
    // ****************************************
    wire logic [W:0] diff = {value_a[W-1], value_a} - {value_b[W-1], value_b};
    wire logic [W:0] mag  = diff[W] ? (~diff + 1'b1) : diff;
    wire logic [W:0] thr  = {{(W-15){1'b0}}, threshold};
    wire logic over = INCLUSIVE ? (mag >= thr) : (mag > thr);
    assign trip = sample && enable && over;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alarm <= 1'b0;
        end else if (trip) begin
            alarm <= 1'b1;
        end else if (clear) begin
            alarm <= 1'b0;
        end
    end
endmodule : sdem_dev_check
`default_nettype wire

// ### logic/sdem_monitor.sv
// sdem_monitor: servo control deviation error monitor with apb registers
// assumes synchronous inputs on SYS_CLK and a one-cycle CYCLE_STROBE
// Overview of operation
// - select bit 0 enables the position check, and when clear it never alarms.
// - position deviation at or above its threshold alarms and stops the motor.
// - the position threshold resets to 50 mm.
// - select bit 1 enables the model versus feedback speed check.
// - speed deviation above its threshold alarms and stops the motor.
// - the speed threshold resets to 1000 mm/s.
// - select bit 2 enables the command versus feedback thrust check.
// - thrust deviation above its threshold alarms and stops the motor.
// - the thrust threshold resets to 100 percent.
// - any select value 1 to 7 is taken, each bit running its check alone.
// - select resets to 3, position and speed on, thrust off.
// - the test mode switch is caught once after power-up only.
// - in test mode the network link to controller and downstream is cut.
// - with an incremental encoder pole detection runs at first servo-on.
// - a linear motor never raises the battery and absolute alarms.
`timescale 1ns/1ps
`default_nettype none
module sdem_monitor #(
    parameter int POS_W       = 32,
    parameter int SPD_W       = 24,
    parameter int THR_W       = 16,
    parameter int POLE_CYCLES = sdem_pkg::POLE_CYCLES
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RST,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic [31:0]           PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    input  wire logic             CYCLE_STROBE,
    input  wire logic [POS_W-1:0] POS_COMMAND,
    input  wire logic [POS_W-1:0] POS_ACTUAL,
    input  wire logic [SPD_W-1:0] SPD_MODEL,
    input  wire logic [SPD_W-1:0] SPD_FEEDBACK,
    input  wire logic [THR_W-1:0] THRUST_COMMAND,
    input  wire logic [THR_W-1:0] THRUST_FEEDBACK,
    input  wire logic             TEST_MODE_SWITCH,
    input  wire logic             INCREMENTAL_ENC,
    input  wire logic             POLE_DONE_IN,
    output logic                  MOTOR_STOP,
    output logic                  SERVO_ON_STATUS,
    output logic                  POLE_DETECT_RUN,
    output logic                  TEST_MODE,
    output logic                  NET_LINK_ENABLE,
    output logic                  ALARM_VALID,
    output logic [7:0]            ALARM_CODE,
    output logic                  IRQ
);
    // ****************************************
    // apb decode
    // ****************************************
    wire logic acc     = PSEL && PENABLE;
    wire logic wr      = acc && PWRITE;
    wire logic hit_sel = PADDR == sdem_pkg::OFS_SELECT;
    wire logic hit_pos = PADDR == sdem_pkg::OFS_POS_THR;
    wire logic hit_spd = PADDR == sdem_pkg::OFS_SPD_THR;
    wire logic hit_thr = PADDR == sdem_pkg::OFS_THR_THR;
    wire logic hit_st  = PADDR == sdem_pkg::OFS_STATUS;
    wire logic hit_clr = PADDR == sdem_pkg::OFS_INT_CLEAR;
    wire logic hit_en  = PADDR == sdem_pkg::OFS_INT_EN;
    wire logic hit_ctl = PADDR == sdem_pkg::OFS_CONTROL;
    wire logic hit_alm = PADDR == sdem_pkg::OFS_ALARM;
    wire logic mapped  = hit_sel || hit_pos || hit_spd || hit_thr || hit_st
                      || hit_clr || hit_en || hit_ctl || hit_alm;
    wire logic [15:0] wdata16 = PWDATA[15:0];
    wire logic [2:0]  wsel    = PWDATA[2:0];

    // ****************************************
    // configuration registers
    // ****************************************
    logic [2:0]  check_select;
    logic [15:0] pos_thr;
    logic [15:0] spd_thr;
    logic [15:0] thr_thr;
    logic [6:0]  int_en;
    logic        servo_on_req;
    // out of range writes are ignored so each threshold stays legal
    wire logic sel_ok = wsel >= sdem_pkg::SELECT_MIN;
    wire logic pos_ok = wdata16 >= sdem_pkg::POS_THR_MIN
                     && wdata16 <= sdem_pkg::POS_THR_MAX;
    wire logic spd_ok = wdata16 >= sdem_pkg::SPD_THR_MIN
                     && wdata16 <= sdem_pkg::SPD_THR_MAX;
    wire logic thr_ok = wdata16 >= sdem_pkg::THR_THR_MIN
                     && wdata16 <= sdem_pkg::THR_THR_MAX;
    wire logic alarm_reset = wr && hit_ctl && PWDATA[sdem_pkg::CTL_RESET_BIT];

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            check_select <= sdem_pkg::SELECT_RST;
            pos_thr      <= sdem_pkg::POS_THR_RST;
            spd_thr      <= sdem_pkg::SPD_THR_RST;
            thr_thr      <= sdem_pkg::THR_THR_RST;
            int_en       <= 7'h00;
            servo_on_req <= 1'b0;
        end else begin
            if (wr && hit_sel && sel_ok) check_select <= wsel;
            if (wr && hit_pos && pos_ok) pos_thr <= wdata16;
            if (wr && hit_spd && spd_ok) spd_thr <= wdata16;
            if (wr && hit_thr && thr_ok) thr_thr <= wdata16;
            if (wr && hit_en) int_en <= PWDATA[6:0];
            if (wr && hit_ctl) servo_on_req <= PWDATA[sdem_pkg::CTL_SVON_BIT];
        end
    end

    // ****************************************
    // power-up capture of test mode switch
    // ****************************************
    logic captured;
    logic test_mode;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            captured  <= 1'b0;
            test_mode <= 1'b0;
        end else if (!captured) begin
            captured  <= 1'b1;
            test_mode <= TEST_MODE_SWITCH;
        end
    end

    // ****************************************
    // deviation checks
    // ****************************************
    wire logic pos_alarm;
    wire logic spd_alarm;
    wire logic thr_alarm;
    wire logic pos_trip;
    wire logic spd_trip;
    wire logic thr_trip;
    sdem_dev_check #(.W(POS_W), .INCLUSIVE(1'b1)) u_pos (
        .clk       (SYS_CLK),
        .rst       (RST),
        .sample    (CYCLE_STROBE),
        .enable    (check_select[sdem_pkg::SEL_POS_BIT]),
        .clear     (alarm_reset),
        .value_a   (POS_COMMAND),
        .value_b   (POS_ACTUAL),
        .threshold (pos_thr),
        .alarm     (pos_alarm),
        .trip      (pos_trip)
    );
    sdem_dev_check #(.W(SPD_W), .INCLUSIVE(1'b0)) u_spd (
        .clk       (SYS_CLK),
        .rst       (RST),
        .sample    (CYCLE_STROBE),
        .enable    (check_select[sdem_pkg::SEL_SPD_BIT]),
        .clear     (alarm_reset),
        .value_a   (SPD_MODEL),
        .value_b   (SPD_FEEDBACK),
        .threshold (spd_thr),
        .alarm     (spd_alarm),
        .trip      (spd_trip)
    );
    sdem_dev_check #(.W(THR_W), .INCLUSIVE(1'b0)) u_thr (
        .clk       (SYS_CLK),
        .rst       (RST),
        .sample    (CYCLE_STROBE),
        .enable    (check_select[sdem_pkg::SEL_THR_BIT]),
        .clear     (alarm_reset),
        .value_a   (THRUST_COMMAND),
        .value_b   (THRUST_FEEDBACK),
        .threshold (thr_thr),
        .alarm     (thr_alarm),
        .trip      (thr_trip)
    );
    wire logic any_alarm = pos_alarm || spd_alarm || thr_alarm;

    // ****************************************
    // servo-on and pole detection
    // ****************************************
    typedef enum logic [1:0] {S_OFF, S_POLE, S_ON} sdem_servo_e;
    sdem_servo_e state;
    sdem_servo_e next_state;
    logic        pole_done;
    logic [$clog2(POLE_CYCLES+1)-1:0] pole_cnt;
    wire logic pole_end = POLE_DONE_IN
                       || pole_cnt == ($clog2(POLE_CYCLES+1))'(POLE_CYCLES);
    wire logic want_on  = servo_on_req && !any_alarm && !test_mode;

    always_comb begin
        next_state = state;
        case (state)
            S_OFF: begin
                if (want_on) begin
                    next_state = (INCREMENTAL_ENC && !pole_done) ? S_POLE : S_ON;
                end
            end
            S_POLE: begin
                if (!want_on) next_state = S_OFF;
                else if (pole_end) next_state = S_ON;
            end
            S_ON: begin
                if (!want_on) next_state = S_OFF;
            end
            default: next_state = S_OFF;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state     <= S_OFF;
            pole_done <= 1'b0;
            pole_cnt  <= '0;
        end else begin
            state <= next_state;
            if (state == S_POLE && pole_end && want_on) pole_done <= 1'b1;
            pole_cnt <= (state == S_POLE) ? pole_cnt + 1'b1 : '0;
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    logic [6:0] status;
    wire logic [6:0] events = {4'h0, thr_trip, spd_trip, pos_trip};
    wire logic [6:0] clr_bits = (wr && hit_clr) ? PWDATA[6:0] : 7'h00;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            status <= 7'h00;
        end else begin
            // set wins over clear
            status <= events | (status & ~clr_bits);
        end
    end

    // ****************************************
    // read mux and outputs
    // ****************************************
    wire logic [6:0] state_bits = {1'b1, test_mode, state == S_ON,
                                   pole_done, thr_alarm, spd_alarm, pos_alarm};
    wire logic [7:0] code_now = pos_alarm ? 8'h42 : spd_alarm ? 8'h42
                             : thr_alarm ? 8'h42 : 8'h00;
    wire logic [31:0] alm_word = {17'h0, thr_alarm, spd_alarm, pos_alarm,
                                  1'b0, state_bits[6:4],
                                  code_now & {8{any_alarm}}};
    wire logic [31:0] rdata =
        hit_sel ? {29'h0, check_select}
      : hit_pos ? {16'h0, pos_thr}
      : hit_spd ? {16'h0, spd_thr}
      : hit_thr ? {16'h0, thr_thr}
      : hit_st  ? {25'h0, status}
      : hit_en  ? {25'h0, int_en}
      : hit_ctl ? {30'h0, servo_on_req, 1'b0}
      : hit_alm ? alm_word
      : 32'h0;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            PRDATA          <= 32'h0;
            PREADY          <= 1'b0;
            PSLVERR         <= 1'b0;
            MOTOR_STOP      <= 1'b1;
            SERVO_ON_STATUS <= 1'b0;
            POLE_DETECT_RUN <= 1'b0;
            TEST_MODE       <= 1'b0;
            NET_LINK_ENABLE <= 1'b0;
            ALARM_VALID     <= 1'b0;
            ALARM_CODE      <= 8'h00;
            IRQ             <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !mapped;
            PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rdata : 32'h0;
            MOTOR_STOP      <= any_alarm || state != S_ON;
            // confirmed status lets the controller interlock its commands
            SERVO_ON_STATUS <= state == S_ON;
            POLE_DETECT_RUN <= state == S_POLE;
            TEST_MODE       <= test_mode;
            NET_LINK_ENABLE <= captured && !test_mode;
            ALARM_VALID     <= any_alarm;
            // only the deviation group is ever coded; battery codes never
            ALARM_CODE      <= any_alarm ? 8'h42 : 8'h00;
            IRQ             <= |(status & int_en);
        end
    end
endmodule : sdem_monitor
`default_nettype wire

// ### verif/sdem_ctl_model.sv
// sdem_ctl_model: motion controller stand-in for the deviation monitor
// assumes the monitor's SYS_CLK and RST, and a target set before servo-on
`timescale 1ns/1ps
`default_nettype none
module sdem_ctl_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        servo_on,
    input  wire logic [31:0] target,
    output logic             strobe,
    output logic [31:0]      pos_cmd
);
    // ****************************************
    // control cycle and command issue
    // ****************************************
    logic [1:0] phase;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase   <= 2'h0;
            strobe  <= 1'b0;
            pos_cmd <= 32'h0;
        end else begin
            phase  <= phase + 2'h1;
            strobe <= (phase == 2'h3);
            if (servo_on) pos_cmd <= target;
        end
    end
endmodule : sdem_ctl_model
`default_nettype wire

// ### verif/sdem_monitor_checker.sv
// sdem_monitor_checker: port assertions for the deviation monitor
// assumes POLE_CYCLES is handed on from the monitor instance
`timescale 1ns/1ps
`default_nettype none
module sdem_monitor_checker #(
    parameter int POLE_CYCLES = 8
) (
    input wire logic        SYS_CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        CYCLE_STROBE,
    input wire logic        INCREMENTAL_ENC,
    input wire logic        MOTOR_STOP,
    input wire logic        POLE_DETECT_RUN,
    input wire logic        TEST_MODE,
    input wire logic        NET_LINK_ENABLE,
    input wire logic        ALARM_VALID,
    input wire logic [7:0]  ALARM_CODE
);
    localparam int POLE_MAX = POLE_CYCLES + 2;
    logic clr_wr;
    assign clr_wr = PSEL & PENABLE & PWRITE & (PADDR == 8'h1C) & PWDATA[0];
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // ****************************************
    // assertions
    // ****************************************
    AST_PREADY_PULSE:
        assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("pready not one access cycle");
    AST_UNMAPPED_ERR:
        assert property (PREADY && PADDR > 8'h20 |-> PSLVERR)
        else $error("no error on unmapped address");
    AST_STOP_WITH_ALARM:
        assert property ($rose(ALARM_VALID) |-> MOTOR_STOP)
        else $error("motor not stopped on alarm");
    AST_ALARM_CAUSE:
        assert property ($rose(ALARM_VALID) |-> $past(CYCLE_STROBE, 2))
        else $error("alarm without control cycle sample");
    AST_ALARM_LATCH:
        assert property (ALARM_VALID && !clr_wr && !$past(clr_wr)
            && !$past(clr_wr, 2) |=> ALARM_VALID)
        else $error("alarm dropped without reset");
    AST_NO_ABS_CODES:
        assert property (!(ALARM_CODE inside {8'h25, 8'h92, 8'h9F, 8'hE3}))
        else $error("absolute or battery code raised");
    AST_TEST_CUTS_LINK:
        assert property (TEST_MODE |-> !NET_LINK_ENABLE)
        else $error("link up in test mode");
    AST_TEST_AT_POWERUP:
        assert property ($changed(TEST_MODE) |-> $past(RST) || $past(RST, 2)
            || $past(RST, 3))
        else $error("test mode changed while running");
    AST_POLE_BOUNDED:
        assert property ($rose(POLE_DETECT_RUN) |-> INCREMENTAL_ENC
            ##[1:POLE_MAX] !POLE_DETECT_RUN)
        else $error("pole detection unbounded or not incremental");
    COV_ALARM: cover property ($rose(ALARM_VALID));
    COV_POLE:  cover property ($rose(POLE_DETECT_RUN));
    COV_ERR:   cover property (PREADY && PSLVERR);
endmodule : sdem_monitor_checker
bind sdem_monitor sdem_monitor_checker #(.POLE_CYCLES(POLE_CYCLES)) u_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CYCLE_STROBE(CYCLE_STROBE),
    .INCREMENTAL_ENC(INCREMENTAL_ENC), .MOTOR_STOP(MOTOR_STOP),
    .POLE_DETECT_RUN(POLE_DETECT_RUN), .TEST_MODE(TEST_MODE),
    .NET_LINK_ENABLE(NET_LINK_ENABLE), .ALARM_VALID(ALARM_VALID),
    .ALARM_CODE(ALARM_CODE));
`default_nettype wire

// ### verif/test_sdem_monitor.sv
// test_sdem_monitor: random and corner-case bench for the monitor
// assumes sdem_ctl_model as controller and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_sdem_monitor;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, tsw = 1'b0, inc = 1'b1, pdone = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, pos_act = 32'h0, tgt = 32'h0, rd;
    logic [23:0] spd_m = 24'h0, spd_f = 24'h0;
    logic [15:0] thr_c = 16'h0, thr_f = 16'h0, seed = 16'h0061;
    logic        er;
    int          miscompares = 0, samples_checked = 0;
    wire logic [31:0] prdata, pos_cmd;
    wire logic [7:0]  acode;
    wire logic pready, pslverr, strobe, stop, svon, prun, tmode, link;
    wire logic avalid, irq;
    logic [7:0]  adr_tab [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    logic [31:0] rst_tab [4] = '{32'h3, 32'h32, 32'h3E8, 32'h64};
    logic [31:0] bad_tab [4] = '{32'h0, 32'h3E9, 32'h1389, 32'h3E9};
    sdem_monitor #(.POLE_CYCLES(8)) uut (
        .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CYCLE_STROBE(strobe), .POS_COMMAND(pos_cmd),
        .POS_ACTUAL(pos_act), .SPD_MODEL(spd_m), .SPD_FEEDBACK(spd_f),
        .THRUST_COMMAND(thr_c), .THRUST_FEEDBACK(thr_f),
        .TEST_MODE_SWITCH(tsw), .INCREMENTAL_ENC(inc), .POLE_DONE_IN(pdone),
        .MOTOR_STOP(stop), .SERVO_ON_STATUS(svon), .POLE_DETECT_RUN(prun),
        .TEST_MODE(tmode), .NET_LINK_ENABLE(link), .ALARM_VALID(avalid),
        .ALARM_CODE(acode), .IRQ(irq));
    sdem_ctl_model u_ctl (.clk(clk), .rst(rst), .servo_on(svon),
        .target(tgt), .strobe(strobe), .pos_cmd(pos_cmd));
    // ****************************************
    // helpers
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) miscompares++;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd
    function automatic logic trips(input int k, input logic [2:0] s,
                                   input int d, input int t);
        return s[k] && (k == 0 ? d >= t : d > t);
    endfunction : trips
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // ****************************************
    // stimulus
    // ****************************************
    initial forever #5 clk = ~clk;
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        int t, d;
        logic [2:0] s, en, st;
        logic [31:0] p;
        logic saw;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        p = {rnd(), rnd()};
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, adr_tab[i], 32'h0);
            chk(rd, rst_tab[i]);
            apb(1'b1, adr_tab[i], bad_tab[i]);
            apb(1'b0, adr_tab[i], 32'h0);
            chk(rd, rst_tab[i]);
        end
        apb(1'b0, 8'h24, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 8'h1C, 32'h2);
        saw = 1'b0;
        for (int n = 0; n < 40 && svon !== 1'b1; n++) begin
            @(posedge clk);
            saw |= (prun === 1'b1);
        end
        chk({saw, svon}, 32'h3);
        tgt     <= p;
        pos_act <= p;
        repeat (8) @(posedge clk);
        apb(1'b1, 8'h1C, 32'h3);
        apb(1'b1, 8'h14, 32'h7);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h500);
        for (int i = 1; i < 8; i++) begin
            en = 3'(rnd());
            apb(1'b1, 8'h18, 32'(en));
            for (int k = 0; k < 3; k++) begin
                s = 3'(i);
                t = (i == 7) ? 1000 : 1 + rnd() % 1000;
                d = t + int'(rnd() % 3) - 1;
                apb(1'b1, 8'h00, 32'(s));
                apb(1'b1, 8'h04 + 8'(4 * k), 32'(t));
                pos_act <= (k == 0) ? p - 32'(d) : p;
                spd_m   <= (k == 1) ? 24'(d) : 24'h0;
                thr_c   <= (k == 2) ? -16'(d) : 16'h0;
                repeat (8) @(posedge clk);
                st = 3'(trips(k, s, d, t)) << k;
                apb(1'b0, 8'h10, 32'h0);
                chk(rd, 32'(st));
                chk({avalid, stop | ~|st}, {31'(|st), 1'b1});
                chk(irq, 32'(|(st & en)));
                chk(acode, (|st) ? 32'h42 : 32'h0);
                pos_act <= p;
                spd_m   <= 24'h0;
                thr_c   <= 16'h0;
                repeat (8) @(posedge clk);
                apb(1'b1, 8'h1C, 32'h3);
                apb(1'b1, 8'h14, 32'h7);
                repeat (3) @(posedge clk);
                chk({avalid, irq}, 32'h0);
            end
        end
        tsw <= 1'b1;
        repeat (4) @(posedge clk);
        chk({tmode, link}, 32'h1);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({tmode, link}, 32'h2);
        end_of_test();
    end
endmodule : test_sdem_monitor
`default_nettype wire
